/* logic/flash_pin_control.sv */
// pin multiplexing, protection, acceleration window and array map of the serial flash
`timescale 1ns/1ps
`include "flash_pin_consts.svh"

module flash_pin_control
#(
  parameter int unsigned VPP_WAIT_CYCLES = `VPP_WAIT_MS * `CORE_CLK_KHZ,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic serialClkPin,
  input wire logic chipSelPin_n,
  input wire logic serialIo0In,
  output logic serialIo0Out,
  output logic serialIo0Oe,
  input wire logic serialIo1In,
  output logic serialIo1Out,
  output logic serialIo1Oe,
  input wire logic serialIo2In,
  output logic serialIo2Out,
  output logic serialIo2Oe,
  input wire logic serialIo3In,
  output logic serialIo3Out,
  output logic serialIo3Oe,
  input wire logic vppHighPin,
  input wire logic quadOpActive,
  input wire logic quadIoProtocol,
  input wire logic readActive,
  input wire logic [7:0] readByte,
  output logic readByteTaken,
  input wire logic resetOptionEn,
  input wire logic resetFuncDisable,
  input wire logic [7:0] nonvolatile_config_reg,
  input wire logic volCfgWrEn,
  input wire logic [7:0] volCfgWrData,
  output logic [7:0] volatile_enhanced_config_reg,
  input wire logic [3:0] block_protect_bits,
  input wire logic topBottom,
  output logic holdActive,
  output logic devReset,
  output logic rxOverrun,
  input wire logic progReady,
  input wire logic [7:0] arrayOldByte,
  output logic mergedValid,
  output logic [7:0] mergedByte,
  input wire logic opValid,
  input wire flash_pin_pkg::op_kind_e opKind,
  input wire logic [`ADDR_W-1:0] opAddr,
  output logic opGranted,
  output logic opRefused,
  output logic [6:0] opSector,
  output logic [10:0] opSubsector,
  output logic [14:0] opPage,
  input wire logic modifyStart,
  input wire logic modifyDone,
  output logic vppDataLine,
  output logic speedFast,
  output logic speedStd
);

  localparam int WAIT_W = $clog2(VPP_WAIT_CYCLES + 1);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] syncA;
  logic [7:0] syncB;
  logic sclkPrev;
  wire logic [7:0] pinsRaw = {vppHighPin, serialIo3In, serialIo2In, serialIo1In,
                              serialIo0In, chipSelPin_n, serialClkPin, 1'b0};

  // cs and pause idle high, so they reset high to avoid a false select
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA <= `SYNC_RESET;
      syncB <= `SYNC_RESET;
      sclkPrev <= 1'b0;
    end
    else
    begin
      syncA <= pinsRaw;
      syncB <= syncA;
      sclkPrev <= syncB[1];
    end
  end

  wire logic sclkS = syncB[1];
  wire logic csS = syncB[2];
  wire logic [3:0] ioS = syncB[6:3];
  wire logic vppS = syncB[7];
  wire logic selected = !csS;
  wire logic sclkRise = sclkS && !sclkPrev;
  wire logic sclkFall = !sclkS && sclkPrev;

  // ------------------------------------------------------------
  // pin function selection
  // ------------------------------------------------------------
  logic [7:0] volCfg;
  wire logic holdEnable = nonvolatile_config_reg[`HOLD_DIS_BIT] && volCfg[`HOLD_DIS_BIT];
  wire logic quadPins = quadOpActive || quadIoProtocol;
  wire logic holdNow = selected && holdEnable && !quadPins && !ioS[3];
  wire logic wpActive = !quadPins && !ioS[2];
  wire logic shiftEn = selected && !holdNow;

  assign holdActive = holdNow;
  assign volatile_enhanced_config_reg = volCfg;

  // ------------------------------------------------------------
  // reset via pause pin and configuration
  // ------------------------------------------------------------
  logic armed;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      devReset <= 1'b0;
      armed <= 1'b0;
      volCfg <= `VOL_CFG_RESET;
    end
    else
    begin
      devReset <= resetOptionEn && !resetFuncDisable && csS && !ioS[3];
      if (selected)
        armed <= 1'b1;
      if (volCfgWrEn)
        volCfg <= volCfgWrData;
    end
  end

  // ------------------------------------------------------------
  // receive shifter feeding the fifo
  // ------------------------------------------------------------
  logic [7:0] rxShift;
  logic [3:0] rxCnt;
  logic rxPending;
  logic [7:0] rxByte;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  wire logic [3:0] rxStep = quadPins ? `NIBBLE_BITS : `SINGLE_BITS;
  wire logic [7:0] rxNext = quadPins ? {rxShift[3:0], ioS} : {rxShift[6:0], ioS[0]};
  wire logic rxDone = (rxCnt + rxStep) == `BYTE_BITS;
  wire logic rxTake = sclkRise && shiftEn && armed;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxShift <= 8'h00;
      rxCnt <= 4'h0;
      rxPending <= 1'b0;
      rxByte <= 8'h00;
      rxOverrun <= 1'b0;
    end
    else
    begin
      if (!selected)
        rxCnt <= 4'h0;
      else if (rxTake && !readActive)
      begin
        rxShift <= rxNext;
        rxCnt <= rxDone ? 4'h0 : rxCnt + rxStep;
      end
      if (rxTake && !readActive && rxDone)
      begin
        rxByte <= rxNext;
        rxPending <= 1'b1;
        // a full fifo cannot stop the host clock; flag the loss instead
        if (rxPending && !fifoInReady)
          rxOverrun <= 1'b1;
      end
      else if (fifoInReady)
        rxPending <= 1'b0;
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inValid(rxPending),
    .inReady(fifoInReady),
    .inData(rxByte),
    .outValid(fifoOutValid),
    .outReady(progReady),
    .outData(fifoOutData)
  );

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mergedValid <= 1'b0;
      mergedByte <= 8'hFF;
    end
    else
    begin
      mergedValid <= fifoOutValid && progReady;
      if (fifoOutValid && progReady)
        mergedByte <= arrayOldByte & fifoOutData;
    end
  end

  // ------------------------------------------------------------
  // transmit shifter
  // ------------------------------------------------------------
  logic [7:0] txShift;
  logic [3:0] txCnt;
  wire logic txEn = sclkFall && shiftEn && readActive;
  wire logic [3:0] txStep = quadPins ? `NIBBLE_BITS : `SINGLE_BITS;
  wire logic [7:0] txSrc = (txCnt == 4'h0) ? readByte : txShift;
  wire logic driveOn = shiftEn && readActive;

  assign serialIo0Oe = driveOn && quadPins;
  assign serialIo1Oe = driveOn;
  assign serialIo2Oe = driveOn && quadPins;
  assign serialIo3Oe = driveOn && quadPins;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txShift <= 8'h00;
      txCnt <= 4'h0;
      readByteTaken <= 1'b0;
      {serialIo3Out, serialIo2Out, serialIo1Out, serialIo0Out} <= 4'h0;
    end
    else
    begin
      readByteTaken <= txEn && (txCnt == 4'h0);
      if (!selected)
        txCnt <= 4'h0;
      else if (txEn)
      begin
        if (quadPins)
          {serialIo3Out, serialIo2Out, serialIo1Out, serialIo0Out} <= txSrc[7:4];
        else
          serialIo1Out <= txSrc[7];
        txShift <= quadPins ? {txSrc[3:0], 4'h0} : {txSrc[6:0], 1'b0};
        txCnt <= ((txCnt + txStep) == `BYTE_BITS) ? 4'h0 : txCnt + txStep;
      end
    end
  end

  // ------------------------------------------------------------
  // address map and protection
  // ------------------------------------------------------------
  // index fields
  wire logic [6:0] secIdx = opAddr[`SECTOR_HI:`SECTOR_LO];
  wire logic [10:0] subIdx = opAddr[`SECTOR_HI:`SUBSECTOR_LO];
  wire logic [14:0] pageIdx = opAddr[`SECTOR_HI:`PAGE_LO];
  wire logic [7:0] protCount = block_protect_bits[3] ? `SECTOR_COUNT :
    (block_protect_bits == 4'h0) ? 8'h00 : 8'h01 << (block_protect_bits[2:0] - 3'h1);
  wire logic inRegion = topBottom ? ({1'b0, secIdx} < protCount) :
    ({1'b0, secIdx} >= (`SECTOR_COUNT - protCount));
  wire logic isBulk = (opKind == flash_pin_pkg::OP_ERASE_BULK);
  wire logic locked = wpActive && (isBulk ? (protCount != 8'h00) : inRegion);
  wire logic outOfMap = opAddr[`ADDR_TOP_BIT];
  wire logic badKind = (opKind == flash_pin_pkg::OP_ERASE_PAGE);
  wire logic refuse = locked || badKind || (outOfMap && !isBulk);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      opGranted <= 1'b0;
      opRefused <= 1'b0;
      opSector <= 7'h00;
      opSubsector <= 11'h000;
      opPage <= 15'h0000;
    end
    else
    begin
      opGranted <= opValid && !refuse;
      opRefused <= opValid && refuse;
      if (opValid)
      begin
        opSector <= secIdx;
        opSubsector <= subIdx;
        opPage <= pageIdx;
      end
    end
  end

  // ------------------------------------------------------------
  // supply acceleration window
  // ------------------------------------------------------------
  flash_pin_pkg::accel_state_e accState;
  flash_pin_pkg::accel_state_e next_accState;
  logic [WAIT_W-1:0] waitCnt;
  wire logic waitOver = (waitCnt == WAIT_W'(VPP_WAIT_CYCLES - 1));
  wire logic accelAllowed = !volCfg[`ACCEL_DIS_BIT] && quadPins;

  always_comb
  begin
    next_accState = accState;
    case (accState)
      flash_pin_pkg::ACC_IDLE:
        if (modifyStart)
          next_accState = accelAllowed ? flash_pin_pkg::ACC_WAIT : flash_pin_pkg::ACC_STD;
      flash_pin_pkg::ACC_WAIT:
        if (vppS)
          next_accState = flash_pin_pkg::ACC_FAST;
        else if (waitOver)
          next_accState = flash_pin_pkg::ACC_STD;
      flash_pin_pkg::ACC_FAST,
      flash_pin_pkg::ACC_STD:
        if (modifyDone)
          next_accState = flash_pin_pkg::ACC_IDLE;
      default:
        next_accState = flash_pin_pkg::ACC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      accState <= flash_pin_pkg::ACC_IDLE;
      waitCnt <= '0;
      vppDataLine <= 1'b0;
    end
    else
    begin
      accState <= next_accState;
      waitCnt <= (accState == flash_pin_pkg::ACC_WAIT) ? waitCnt + 1'b1 : '0;
      // supply pin is data until the end
      if (accState == flash_pin_pkg::ACC_IDLE && modifyStart)
        vppDataLine <= accelAllowed;
      else if (modifyDone)
        vppDataLine <= 1'b0;
    end
  end

  assign speedFast = (accState == flash_pin_pkg::ACC_FAST);
  assign speedStd = (accState == flash_pin_pkg::ACC_STD);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_hold_hiz;
    @(posedge core_clk) disable iff (!arst_n) holdActive |-> !serialIo1Oe && !txEn && !rxTake;
  endproperty
  a_hold_hiz: assert property (p_hold_hiz) else $error("pause left output driven");

  property p_hold_needs_select;
    @(posedge core_clk) disable iff (!arst_n) csS |-> !holdActive;
  endproperty
  a_hold_needs_select: assert property (p_hold_needs_select) else $error("pause while deselected");

  property p_quad_no_hold;
    @(posedge core_clk) disable iff (!arst_n) quadPins |-> !holdActive && !wpActive;
  endproperty
  a_quad_no_hold: assert property (p_quad_no_hold) else $error("quad pin kept control role");

  property p_pin_reset;
    @(posedge core_clk) disable iff (!arst_n)
      (resetOptionEn && !resetFuncDisable && csS && !ioS[3]) |=> devReset;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset via pause pin missed");

  property p_hold_disable;
    @(posedge core_clk) disable iff (!arst_n)
      !(nonvolatile_config_reg[`HOLD_DIS_BIT] && volCfg[`HOLD_DIS_BIT]) |-> !holdActive;
  endproperty
  a_hold_disable: assert property (p_hold_disable) else $error("pause active while disabled");

  property p_wp_bulk;
    @(posedge core_clk) disable iff (!arst_n)
      (opValid && isBulk && wpActive && block_protect_bits != 4'h0) |=> opRefused && !opGranted;
  endproperty
  a_wp_bulk: assert property (p_wp_bulk) else $error("bulk erase past protection");

  property p_accel_gate;
    @(posedge core_clk) disable iff (!arst_n)
      $rose(accState == flash_pin_pkg::ACC_WAIT) |-> !volCfg[`ACCEL_DIS_BIT] && vppDataLine;
  endproperty
  a_accel_gate: assert property (p_accel_gate) else $error("acceleration without enable");

  property p_vpp_fast;
    @(posedge core_clk) disable iff (!arst_n)
      (accState == flash_pin_pkg::ACC_WAIT && vppS) |=> speedFast ##1 (speedFast || !vppDataLine);
  endproperty
  a_vpp_fast: assert property (p_vpp_fast) else $error("supply arrival ignored");

  property p_vol_cfg_reset;
    @(posedge core_clk) $rose(arst_n) |-> volCfg == `VOL_CFG_RESET;
  endproperty
  a_vol_cfg_reset: assert property (p_vol_cfg_reset) else $error("volatile register reset wrong");

  property p_merge;
    @(posedge core_clk) disable iff (!arst_n)
      (fifoOutValid && progReady) |=> (mergedByte & ~$past(arrayOldByte)) == 8'h00;
  endproperty
  a_merge: assert property (p_merge) else $error("program set a bit");

  property p_page_erase;
    @(posedge core_clk) disable iff (!arst_n) (opValid && badKind) |=> opRefused && !opGranted;
  endproperty
  a_page_erase: assert property (p_page_erase) else $error("page erase accepted");

  property p_map;
    @(posedge core_clk) disable iff (!arst_n)
      opValid |=> opSubsector == $past(opAddr[`SECTOR_HI:`SUBSECTOR_LO]) &&
        opSector == $past(opAddr[`SECTOR_HI:`SECTOR_LO]);
  endproperty
  a_map: assert property (p_map) else $error("address index wrong");

  property p_deselect_hiz;
    @(posedge core_clk) disable iff (!arst_n) csS |-> !serialIo1Oe && !serialIo3Oe;
  endproperty
  a_deselect_hiz: assert property (p_deselect_hiz) else $error("drive while deselected");

  c_fast: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(speedFast));
  c_std: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(speedStd));
  c_hold: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(holdActive));
  c_prog: cover property (@(posedge core_clk) disable iff (!arst_n) mergedValid);

endmodule

/* logic/flash_pin_consts.svh */
// named constants for the flash pin control and array map block
`ifndef FLASH_PIN_CONSTS_SVH
`define FLASH_PIN_CONSTS_SVH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CORE_CLK_KHZ 100000
`define VPP_WAIT_MS 200

// ------------------------------------------------------------
// configuration register fields and reset values
// ------------------------------------------------------------
`define HOLD_DIS_BIT 4
`define ACCEL_DIS_BIT 3
`define VOL_CFG_RESET 8'hFF
`define SYNC_RESET 8'h7C

// ------------------------------------------------------------
// array organisation
// ------------------------------------------------------------
`define ADDR_W 24
`define SECTOR_HI 22
`define SECTOR_LO 16
`define SUBSECTOR_LO 12
`define PAGE_LO 8
`define ADDR_TOP_BIT 23
`define SECTOR_COUNT 8'h80
`define OTP_BYTES 64
`define BYTE_BITS 4'h8
`define NIBBLE_BITS 4'h4
`define SINGLE_BITS 4'h1
`define FIFO_DEPTH 8

`endif

/* logic/flash_pin_pkg.sv */
// types shared by the flash pin control block
package flash_pin_pkg;

  typedef enum logic [2:0]
  {
    OP_PROGRAM = 3'h0,
    OP_ERASE_SUB = 3'h1,
    OP_ERASE_SECTOR = 3'h2,
    OP_ERASE_BULK = 3'h3,
    OP_ERASE_PAGE = 3'h4
  } op_kind_e;

  typedef enum logic [3:0]
  {
    ACC_IDLE = 4'h1,
    ACC_WAIT = 4'h2,
    ACC_FAST = 4'h4,
    ACC_STD = 4'h8
  } accel_state_e;

endpackage

/* logic/byte_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wrPtr;
  logic [PW:0] rdPtr;
  wire logic pushOk = inValid && inReady;
  wire logic popOk = outValid && outReady;
  wire logic full = (wrPtr[PW] != rdPtr[PW]) && (wrPtr[PW-1:0] == rdPtr[PW-1:0]);
  wire logic empty = (wrPtr == rdPtr);

  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr[PW-1:0]];

  always_ff @(posedge core_clk)
  begin
    if (pushOk)
      mem[wrPtr[PW-1:0]] <= inData;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (pushOk)
        wrPtr <= wrPtr + 1'b1;
      if (popOk)
        rdPtr <= rdPtr + 1'b1;
    end
  end

endmodule

/* sim/host_spi_model.sv */
// host side flash controller model that drives the serial pins
`timescale 1ns/1ps
module host_spi_model
(
  input wire logic core_clk,
  output logic sclk,
  output logic selPin_n,
  output logic io0,
  input wire logic io1,
  output logic io2,
  output logic io3
);
  // half period of four core cycles keeps the serial clock below core_clk/4
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic select(input logic sel);
    selPin_n = !sel;
    wait_clk(4);
  endtask
  // data set while low, sampled on rise
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      io0 = b[i];
      wait_clk(4);
      sclk = 1'h1;
      wait_clk(4);
      sclk = 1'h0;
    end
    // released data line shows the inverse, never a stale bit
    io0 = !b[0];
  endtask
  // each bit read after the falling edge that shifts it out
  task automatic recv_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'h1;
      wait_clk(4);
      sclk = 1'h0;
      wait_clk(4);
      b[i] = io1;
    end
  endtask
  task automatic lines(input logic wp, input logic pause);
    io2 = wp;
    io3 = pause;
    wait_clk(4);
  endtask
  initial
  begin
    sclk = 1'h0;
    selPin_n = 1'h1;
    io0 = 1'h0;
    io2 = 1'h1;
    io3 = 1'h1;
  end
endmodule

/* sim/testbench.sv */
// self-checking bench for the flash pin control block
`timescale 1ns/1ps
module testbench;
  localparam int WAIT_CYCLES = 20;
  logic core_clk, arst_n, sclk, selPin_n, hostIo0, hostIo2, hostIo3;
  logic io0Out, io1Out, io2Out, io3Out, io0Oe, io1Oe, io2Oe, io3Oe, io0Pin, io1Pin, io2Pin, io3Pin;
  logic quadOpActive, resetOptionEn, resetFuncDisable, volCfgWrEn, topBottom, vppHigh, progReady;
  logic quadIo, readActive;
  logic opValid, modifyStart, modifyDone, readByteTaken, holdActive, devReset, rxOverrun;
  logic mergedValid, opGranted, opRefused, vppDataLine, speedFast, speedStd;
  logic [7:0] nvCfg, volCfgWrData, volCfg, oldByte, mergedByte, readByte, rxRead;
  logic [3:0] protBits;
  logic [23:0] opAddr;
  logic [6:0] opSector;
  logic [10:0] opSubsector;
  logic [14:0] opPage;
  flash_pin_pkg::op_kind_e opKind;
  int nFail, comparisons, cycles, nTaken;

  assign io0Pin = io0Oe ? io0Out : hostIo0;
  assign io1Pin = io1Oe ? io1Out : 1'h1;
  assign io2Pin = io2Oe ? io2Out : hostIo2;
  assign io3Pin = io3Oe ? io3Out : hostIo3;

  host_spi_model host (.core_clk(core_clk), .sclk(sclk), .selPin_n(selPin_n), .io0(hostIo0),
    .io1(io1Pin), .io2(hostIo2), .io3(hostIo3));

  flash_pin_control #(.VPP_WAIT_CYCLES(WAIT_CYCLES), .FIFO_DEPTH(8)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .serialClkPin(sclk), .chipSelPin_n(selPin_n),
    .serialIo0In(io0Pin), .serialIo0Out(io0Out), .serialIo0Oe(io0Oe),
    .serialIo1In(io1Pin), .serialIo1Out(io1Out), .serialIo1Oe(io1Oe),
    .serialIo2In(io2Pin), .serialIo2Out(io2Out), .serialIo2Oe(io2Oe),
    .serialIo3In(io3Pin), .serialIo3Out(io3Out), .serialIo3Oe(io3Oe),
    .vppHighPin(vppHigh), .quadOpActive(quadOpActive), .quadIoProtocol(quadIo),
    .readActive(readActive), .readByte(readByte), .readByteTaken(readByteTaken),
    .resetOptionEn(resetOptionEn), .resetFuncDisable(resetFuncDisable),
    .nonvolatile_config_reg(nvCfg), .volCfgWrEn(volCfgWrEn), .volCfgWrData(volCfgWrData),
    .volatile_enhanced_config_reg(volCfg), .block_protect_bits(protBits),
    .topBottom(topBottom),
    .holdActive(holdActive), .devReset(devReset), .rxOverrun(rxOverrun),
    .progReady(progReady), .arrayOldByte(oldByte), .mergedValid(mergedValid),
    .mergedByte(mergedByte), .opValid(opValid), .opKind(opKind), .opAddr(opAddr),
    .opGranted(opGranted), .opRefused(opRefused), .opSector(opSector),
    .opSubsector(opSubsector), .opPage(opPage), .modifyStart(modifyStart),
    .modifyDone(modifyDone), .vppDataLine(vppDataLine), .speedFast(speedFast),
    .speedStd(speedStd));

  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = !core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      nFail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic flag(input string what, input logic exp, input logic got);
    check(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  task automatic request(input flash_pin_pkg::op_kind_e k, input logic [23:0] a, input logic g);
    opKind = k;
    opAddr = a;
    opValid = 1'h1;
    tick(1);
    opValid = 1'h0;
    flag("opGranted", g, opGranted);
    flag("opRefused", !g, opRefused);
    tick(1);
  endtask
  task automatic complete_run;
    if (nFail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    check("volCfg", 16'h00FF, {8'h00, volCfg});
    check("oe", 16'h0000, {12'h000, io0Oe, io1Oe, io2Oe, io3Oe});
    flag("speedStd", 1'h0, speedStd);
  endtask
  task automatic t_pause;
    host.select(1'h1);
    host.lines(1'h1, 1'h0);
    flag("holdActive", 1'h1, holdActive);
    flag("io1Oe", 1'h0, io1Oe);
    quadOpActive = 1'h1;
    tick(1);
    flag("holdActive quad", 1'h0, holdActive);
    quadOpActive = 1'h0;
    nvCfg = 8'hEF;
    tick(1);
    flag("holdActive nvCfg", 1'h0, holdActive);
    nvCfg = 8'hFF;
    host.select(1'h0);
    flag("holdActive deselected", 1'h0, holdActive);
    resetOptionEn = 1'h1;
    tick(2);
    flag("devReset", 1'h1, devReset);
    resetFuncDisable = 1'h1;
    tick(2);
    flag("devReset disabled", 1'h0, devReset);
    resetOptionEn = 1'h0;
    resetFuncDisable = 1'h0;
    host.lines(1'h1, 1'h1);
  endtask
  task automatic t_merge;
    progReady = 1'h1;
    oldByte = 8'h0F;
    host.select(1'h1);
    host.send_byte(8'hA5);
    tick(6);
    check("mergedByte", 16'h0005, {8'h00, mergedByte});
    oldByte = 8'hFF;
    host.send_byte(8'h3C);
    tick(6);
    check("mergedByte", 16'h003C, {8'h00, mergedByte});
    host.select(1'h0);
  endtask
  task automatic t_fifo;
    int n;
    n = 0;
    progReady = 1'h0;
    host.select(1'h1);
    for (int i = 0; i < 9; i++)
      host.send_byte(8'(i));
    tick(6);
    flag("rxOverrun", 1'h0, rxOverrun);
    host.send_byte(8'h5A);
    tick(6);
    flag("rxOverrun full", 1'h1, rxOverrun);
    progReady = 1'h1;
    for (int i = 0; i < 16; i++)
    begin
      tick(1);
      if (mergedValid === 1'h1)
        n++;
    end
    check("drained", 16'h0009, 16'(n));
    check("last byte", 16'h005A, {8'h00, mergedByte});
    host.select(1'h0);
  endtask
  task automatic t_ops;
    for (int k = 0; k < 5; k++)
      request(flash_pin_pkg::op_kind_e'(k), 24'h7FF000, k != 4);
    check("opSector", 16'h007F, 16'(opSector));
    check("opSubsector", 16'h07FF, 16'(opSubsector));
    check("opPage", 16'h7FF0, 16'(opPage));
    request(flash_pin_pkg::OP_ERASE_SUB, 24'h000FFF, 1'h1);
    check("opSubsector", 16'h0000, 16'(opSubsector));
    request(flash_pin_pkg::OP_PROGRAM, 24'h800000, 1'h0);
  endtask
  task automatic t_protect;
    protBits = 4'h1;
    host.lines(1'h0, 1'h1);
    request(flash_pin_pkg::OP_ERASE_SECTOR, 24'h7F0000, 1'h0);
    request(flash_pin_pkg::OP_ERASE_SECTOR, 24'h7E0000, 1'h1);
    request(flash_pin_pkg::OP_ERASE_BULK, 24'h000000, 1'h0);
    topBottom = 1'h1;
    request(flash_pin_pkg::OP_ERASE_SECTOR, 24'h000000, 1'h0);
    protBits = 4'h7;
    request(flash_pin_pkg::OP_ERASE_SECTOR, 24'h3F0000, 1'h0);
    request(flash_pin_pkg::OP_ERASE_SECTOR, 24'h400000, 1'h1);
    protBits = 4'h8;
    request(flash_pin_pkg::OP_ERASE_SECTOR, 24'h7F0000, 1'h0);
    quadOpActive = 1'h1;
    request(flash_pin_pkg::OP_ERASE_SECTOR, 24'h000000, 1'h1);
    quadOpActive = 1'h0;
    host.lines(1'h1, 1'h1);
    request(flash_pin_pkg::OP_ERASE_SECTOR, 24'h000000, 1'h1);
    protBits = 4'h0;
  endtask
  task automatic t_accel;
    pulse(modifyStart);
    flag("speedStd default", 1'h1, speedStd);
    flag("vppDataLine", 1'h0, vppDataLine);
    tick(1);
    pulse(modifyDone);
    volCfgWrData = 8'hF7;
    tick(1);
    pulse(volCfgWrEn);
    check("volCfg", 16'h00F7, {8'h00, volCfg});
    quadOpActive = 1'h1;
    pulse(modifyStart);
    flag("speedFast wait", 1'h0, speedFast | speedStd);
    tick(1);
    flag("vppDataLine", 1'h1, vppDataLine);
    tick(WAIT_CYCLES + 2);
    flag("speedStd late", 1'h1, speedStd);
    pulse(modifyDone);
    tick(1);
    pulse(modifyStart);
    vppHigh = 1'h1;
    tick(5);
    flag("speedFast", 1'h1, speedFast);
    vppHigh = 1'h0;
    quadOpActive = 1'h0;
    pulse(modifyDone);
  endtask
  task automatic t_read;
    readByte = 8'h96;
    readActive = 1'h1;
    host.select(1'h1);
    flag("io1Oe read", 1'h1, io1Oe);
    host.recv_byte(rxRead);
    check("read byte", 16'h0096, {8'h00, rxRead});
    check("readByteTaken", 16'h0001, 16'(nTaken));
    quadIo = 1'h1;
    tick(1);
    flag("io3Oe quad", 1'h1, io3Oe);
    flag("io2Oe quad", 1'h1, io2Oe);
    host.select(1'h0);
    flag("io1Oe deselected", 1'h0, io1Oe);
    quadIo = 1'h0;
    readActive = 1'h0;
  endtask

  // tests need about 1000 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (readByteTaken === 1'h1)
      nTaken++;
    if (cycles == 20000)
    begin
      nFail++;
      complete_run();
    end
  end

  initial
  begin
    {arst_n, quadOpActive, resetOptionEn, resetFuncDisable, volCfgWrEn, topBottom} = 6'h00;
    {vppHigh, progReady, opValid, modifyStart, modifyDone, quadIo, readActive} = 7'h00;
    {nvCfg, volCfgWrData, oldByte, protBits, opAddr} = {8'hFF, 8'hFF, 8'hFF, 4'h0, 24'h000000};
    readByte = 8'h00;
    nTaken = 0;
    opKind = flash_pin_pkg::OP_PROGRAM;
    nFail = 0;
    comparisons = 0;
    cycles = 0;
    tick(10);
    t_reset();
    arst_n = 1'h1;
    tick(2);
    t_pause();
    t_merge();
    t_fifo();
    t_ops();
    t_protect();
    t_accel();
    t_read();
    complete_run();
  end
endmodule
